/* verilog/timer_regs.svh */
// Register offsets, field positions, reset values and encodings of the timer half.
`ifndef TIMER_REGS_SVH
`define TIMER_REGS_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define OFF_CONFIG 12'h000
`define OFF_MODE 12'h004
`define OFF_CONTROL 12'h00C
`define OFF_MASK 12'h018
`define OFF_RAW 12'h01C
`define OFF_MASKED 12'h020
`define OFF_CLEAR 12'h024
`define OFF_LOAD 12'h028
`define OFF_MATCH 12'h030
`define OFF_CAPTURE 12'h048

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define MODE_FIELD_LSB 0
`define MODE_CMR_BIT 2
`define MODE_AMS_BIT 3
`define CTL_EN_BIT 0
`define CTL_EVT_LSB 2
`define CTL_INV_BIT 6
`define FLAG_TIMEOUT 0
`define FLAG_MATCH 1
`define FLAG_CAPTURE 2

// ---------------------------------------------------------------
// Encodings and reset values
// ---------------------------------------------------------------
`define CFG_WIDE 3'h0
`define CFG_SPLIT 3'h4
`define TMODE_ONESHOT 2'h1
`define TMODE_PERIODIC 2'h2
`define TMODE_CAPTURE 2'h3
`define EVT_RISE 2'h0
`define EVT_FALL 2'h1
`define EVT_BOTH 2'h3
`define LOAD_RESET 32'hFFFFFFFF
`define MATCH_RESET 32'hFFFFFFFF
`define COUNT_RESET 32'hFFFFFFFF
`define CAPTURE_RESET 16'hFFFF

`endif

/* verilog/timer_pkg.sv */
// Types shared by the timer half.
package timer_pkg;

	// Operating mode decoded from configuration, mode field and select bits.
	typedef enum logic [4:0] {
		OP_NONE = 5'h01,
		OP_TIMER = 5'h02,
		OP_EDGE_COUNT = 5'h04,
		OP_EDGE_TIME = 5'h08,
		OP_PWM = 5'h10
	} op_type;

endpackage

/* verilog/edge_sync_detect.sv */
// Two-stage synchroniser and edge detector for the capture pin.
`timescale 1ns/100ps
module edge_sync_detect (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Pin side
	input wire logic pin_in,
	// Edge events
	output logic rise_pulse,
	output logic fall_pulse
);

	logic sync1_r;
	logic sync2_r;
	logic prev_r;

	// ---------------------------------------------------------------
	// Synchroniser
	// ---------------------------------------------------------------

	// Only the second stage is looked at, so metastability stays in the first.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_r <= 1'h0;
			sync2_r <= 1'h0;
			prev_r <= 1'h0;
		end else begin
			sync1_r <= pin_in;
			sync2_r <= sync1_r;
			prev_r <= sync2_r;
		end
	end

	// Pulses last one cycle; the pin must hold two cycles per level or its edges land in adjacent cycles.
	assign rise_pulse = sync2_r & ~prev_r;
	assign fall_pulse = ~sync2_r & prev_r;

	chk_single_rise: assert property (@(posedge pclk) disable iff (!presetn)
		rise_pulse |=> !rise_pulse && !fall_pulse) else $error("rise pulse longer than one cycle");

endmodule

/* verilog/status_flag.sv */
// One sticky status flag: hardware sets it, software clears it, set wins.
`timescale 1ns/100ps
module status_flag (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Control
	input wire logic set_pulse,
	input wire logic clear_pulse,
	// State
	output logic flag
);

	// A set in the clearing cycle survives so that no event is lost.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag <= 1'h0;
		end else if (set_pulse) begin
			flag <= 1'h1;
		end else if (clear_pulse) begin
			flag <= 1'h0;
		end
	end

	chk_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
		set_pulse |=> flag) else $error("flag set was lost");

endmodule

/* verilog/timer_edge_capture_pwm.sv */
// Timer half with edge count, edge time, PWM and one-shot/periodic modes behind APB.
`timescale 1ns/100ps
`include "timer_regs.svh"
module timer_edge_capture_pwm (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	// Pins
	input wire logic capture_pin,
	output logic pwm_out
);
	import timer_pkg::*;

	logic [2:0] configuration_r;
	logic [1:0] timer_mode_field_r;
	logic capture_mode_select_r;
	logic alternate_mode_select_r;
	logic enable_r;
	logic [1:0] edge_event_r;
	logic pwm_output_invert_r;
	logic [2:0] mask_r;
	logic [31:0] load_r;
	logic [31:0] match_r;
	logic [31:0] count_r;
	logic [15:0] capture_r;
	logic load_pending_r;
	logic pwm_level_r;
	logic [2:0] raw_flags;
	op_type op;
	logic split;
	logic [31:0] load_val;
	logic [31:0] match_val;
	logic [31:0] count_dec;
	logic rise_evt;
	logic fall_evt;
	logic count_edge;
	logic time_edge;
	logic timeout_evt;
	logic match_evt;
	logic capture_evt;
	logic wr_access;
	logic wr_control;
	logic wr_load;
	logic wr_clear;
	logic enable_start;
	logic addr_hit;
	logic [31:0] read_val;

	// ---------------------------------------------------------------
	// Pin edges
	// ---------------------------------------------------------------

	edge_sync_detect pin_edges (
		.pclk(pclk),
		.presetn(presetn),
		.pin_in(capture_pin),
		.rise_pulse(rise_evt),
		.fall_pulse(fall_evt)
	);

	// Both edges are legal for counting; timing takes only one kind, both falls back to rising.
	always_comb begin
		unique case (edge_event_r)
			`EVT_RISE: count_edge = rise_evt;
			`EVT_FALL: count_edge = fall_evt;
			`EVT_BOTH: count_edge = rise_evt | fall_evt;
			default: count_edge = 1'h0;
		endcase
		time_edge = (edge_event_r == `EVT_FALL) ? fall_evt : rise_evt;
	end

	// ---------------------------------------------------------------
	// Mode decode
	// ---------------------------------------------------------------

	// Edge and PWM modes exist only in the split configuration.
	always_comb begin
		split = (configuration_r == `CFG_SPLIT);
		op = OP_NONE;
		if (split && timer_mode_field_r == `TMODE_CAPTURE) begin
			op = capture_mode_select_r ? OP_EDGE_TIME : OP_EDGE_COUNT;
		end else if (split && alternate_mode_select_r && !capture_mode_select_r &&
			timer_mode_field_r == `TMODE_PERIODIC) begin
			op = OP_PWM;
		end else if (!alternate_mode_select_r && (configuration_r == `CFG_WIDE || split) &&
			(timer_mode_field_r == `TMODE_ONESHOT || timer_mode_field_r == `TMODE_PERIODIC)) begin
			op = OP_TIMER;
		end
		load_val = split ? {16'h0000, load_r[15:0]} : load_r;
		match_val = split ? {16'h0000, match_r[15:0]} : match_r;
		count_dec = count_r - 32'h00000001;
	end

	// ---------------------------------------------------------------
	// Events
	// ---------------------------------------------------------------

	// Flags come only from timer, count and time modes, never from PWM.
	assign timeout_evt = enable_r && !load_pending_r && op == OP_TIMER && count_r == 32'h00000000;
	assign match_evt = enable_r && !load_pending_r && op == OP_EDGE_COUNT && count_edge &&
		count_dec == match_val;
	assign capture_evt = enable_r && op == OP_EDGE_TIME && time_edge;

	// ---------------------------------------------------------------
	// APB decode
	// ---------------------------------------------------------------

	assign wr_access = psel && penable && pready && pwrite;
	assign wr_control = wr_access && paddr == `OFF_CONTROL;
	assign wr_load = wr_access && paddr == `OFF_LOAD;
	assign wr_clear = wr_access && paddr == `OFF_CLEAR;
	assign enable_start = wr_control && pwdata[`CTL_EN_BIT] && !enable_r;

	// Read mux; the capture address shows the live count outside edge time mode.
	always_comb begin
		addr_hit = 1'h1;
		read_val = 32'h00000000;
		unique case (paddr)
			`OFF_CONFIG: read_val = {29'h00000000, configuration_r};
			`OFF_MODE: read_val = {28'h0000000, alternate_mode_select_r, capture_mode_select_r, timer_mode_field_r};
			`OFF_CONTROL: read_val = {25'h0000000, pwm_output_invert_r, 2'h0, edge_event_r, 1'h0, enable_r};
			`OFF_MASK: read_val = {29'h00000000, mask_r};
			`OFF_RAW: read_val = {29'h00000000, raw_flags};
			`OFF_MASKED: read_val = {29'h00000000, raw_flags & mask_r};
			`OFF_CLEAR: read_val = 32'h00000000;
			`OFF_LOAD: read_val = load_r;
			`OFF_MATCH: read_val = match_r;
			`OFF_CAPTURE: read_val = (op == OP_EDGE_TIME) ? {16'h0000, capture_r} : count_r;
			default: addr_hit = 1'h0;
		endcase
	end

	// Answer prepared in setup, so the access phase completes without wait states.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'h0;
			prdata <= 32'h00000000;
			pslverr <= 1'h0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !addr_hit;
			prdata <= (psel && !penable && !pwrite) ? read_val : 32'h00000000;
		end
	end

	// ---------------------------------------------------------------
	// Configuration registers
	// ---------------------------------------------------------------

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			configuration_r <= `CFG_WIDE;
			timer_mode_field_r <= 2'h0;
			capture_mode_select_r <= 1'h0;
			alternate_mode_select_r <= 1'h0;
			edge_event_r <= `EVT_RISE;
			pwm_output_invert_r <= 1'h0;
			mask_r <= 3'h0;
			load_r <= `LOAD_RESET;
			match_r <= `MATCH_RESET;
		end else if (wr_access) begin
			unique case (paddr)
				`OFF_CONFIG: configuration_r <= pwdata[2:0];
				`OFF_MODE: begin
					timer_mode_field_r <= pwdata[`MODE_FIELD_LSB +: 2];
					capture_mode_select_r <= pwdata[`MODE_CMR_BIT];
					alternate_mode_select_r <= pwdata[`MODE_AMS_BIT];
				end
				`OFF_CONTROL: begin
					edge_event_r <= pwdata[`CTL_EVT_LSB +: 2];
					pwm_output_invert_r <= pwdata[`CTL_INV_BIT];
				end
				`OFF_MASK: mask_r <= pwdata[2:0];
				`OFF_LOAD: load_r <= pwdata;
				`OFF_MATCH: match_r <= pwdata;
				default: ;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Enable
	// ---------------------------------------------------------------

	// Software writes win over the self-clear in the same cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable_r <= 1'h0;
		end else if (wr_control) begin
			enable_r <= pwdata[`CTL_EN_BIT];
		end else if (match_evt) begin
			enable_r <= 1'h0;
		end else if (timeout_evt && timer_mode_field_r == `TMODE_ONESHOT) begin
			enable_r <= 1'h0;
		end
	end

	// ---------------------------------------------------------------
	// Counter
	// ---------------------------------------------------------------

	// A load write takes effect one cycle later, even while running.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			load_pending_r <= 1'h0;
		end else begin
			load_pending_r <= wr_load;
		end
	end

	// One step per clock or per edge; there is no prescaler in this path at all.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_r <= `COUNT_RESET;
		end else if (enable_start || load_pending_r) begin
			count_r <= load_val;
		end else if (enable_r) begin
			unique case (op)
				OP_TIMER, OP_EDGE_TIME, OP_PWM: begin
					count_r <= (count_r == 32'h00000000) ? load_val : count_dec;
				end
				OP_EDGE_COUNT: begin
					if (match_evt) begin
						count_r <= load_val;
					end else if (count_edge) begin
						count_r <= count_dec;
					end
				end
				OP_NONE: ;
			endcase
		end
	end

	// Capture holds its value until the next selected edge.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			capture_r <= `CAPTURE_RESET;
		end else if (capture_evt) begin
			capture_r <= count_r[15:0];
		end
	end

	// ---------------------------------------------------------------
	// Status flags
	// ---------------------------------------------------------------

	// Masked status is derived, so clearing raw clears masked too.
	status_flag timeout_flag (
		.pclk(pclk),
		.presetn(presetn),
		.set_pulse(timeout_evt),
		.clear_pulse(wr_clear && pwdata[`FLAG_TIMEOUT]),
		.flag(raw_flags[`FLAG_TIMEOUT])
	);

	status_flag match_flag (
		.pclk(pclk),
		.presetn(presetn),
		.set_pulse(match_evt),
		.clear_pulse(wr_clear && pwdata[`FLAG_MATCH]),
		.flag(raw_flags[`FLAG_MATCH])
	);

	status_flag capture_flag (
		.pclk(pclk),
		.presetn(presetn),
		.set_pulse(capture_evt),
		.clear_pulse(wr_clear && pwdata[`FLAG_CAPTURE]),
		.flag(raw_flags[`FLAG_CAPTURE])
	);

	// ---------------------------------------------------------------
	// PWM output
	// ---------------------------------------------------------------

	// The level trails the count by one cycle; the pin trails the level by one more.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwm_level_r <= 1'h0;
		end else if (!enable_r || op != OP_PWM) begin
			pwm_level_r <= 1'h0;
		end else if (count_r == load_val) begin
			pwm_level_r <= 1'h1;
		end else if (count_r == match_val) begin
			pwm_level_r <= 1'h0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwm_out <= 1'h0;
		end else begin
			pwm_out <= pwm_level_r ^ pwm_output_invert_r;
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_edge_step: assert property (
		enable_r && op == OP_EDGE_COUNT && count_edge && !match_evt && !load_pending_r && !enable_start
		|=> count_r == $past(count_r) - 32'h00000001) else $error("edge did not decrement count");
	chk_match_stop: assert property (
		match_evt && !wr_control && !wr_load |=> !enable_r && count_r == $past(load_val) && raw_flags[1])
		else $error("match did not reload and stop");
	chk_capture_copy: assert property (
		capture_evt |=> capture_r == $past(count_r[15:0]) && raw_flags[2]) else $error("capture missed");
	chk_capture_hold: assert property (
		!capture_evt |=> capture_r == $past(capture_r)) else $error("capture changed without edge");
	chk_time_wrap: assert property (
		enable_r && op == OP_EDGE_TIME && count_r == 32'h00000000 && !load_pending_r && !enable_start
		|=> count_r == $past(load_val)) else $error("edge time did not reload at zero");
	chk_no_prescale: assert property (
		enable_r && op == OP_PWM && count_r != 32'h00000000 && !load_pending_r && !enable_start
		|=> count_r == $past(count_r) - 32'h00000001) else $error("pwm count not one per clock");
	chk_pwm_quiet: assert property (
		op == OP_PWM && !wr_clear |=> raw_flags == $past(raw_flags)) else $error("flag set in pwm mode");
	chk_pwm_start: assert property (
		enable_r && op == OP_PWM && count_r == load_val && !wr_control && !pwm_output_invert_r
		|=> pwm_level_r ##1 pwm_out) else $error("pwm did not go active at load");
	chk_pwm_invert: assert property (
		pwm_level_r && pwm_output_invert_r && $stable(pwm_output_invert_r) |=> !pwm_out)
		else $error("inverted pwm wrong");
	chk_timeout_clear: assert property (
		wr_clear && pwdata[0] && !timeout_evt |=> !raw_flags[0]) else $error("timeout not cleared");
	chk_oneshot_stop: assert property (
		timeout_evt && timer_mode_field_r == `TMODE_ONESHOT && !wr_control |=> !enable_r)
		else $error("one-shot kept running");

	cov_match: cover property (match_evt);
	cov_capture: cover property (capture_evt ##[1:250] capture_evt);
	cov_pwm_cycle: cover property (op == OP_PWM && pwm_level_r ##[1:200] !pwm_level_r);
	cov_periodic: cover property (timeout_evt && timer_mode_field_r == `TMODE_PERIODIC);

endmodule

/* bench/pin_partner.sv */
// Pin-side model that drives the capture input and measures the PWM output.
`timescale 1ns/100ps
module pin_partner (
	// Clock
	input wire logic pclk,
	// Pins
	output logic capture_pin,
	input wire logic pwm_out
);

	// ----------------------------------------
	// Capture input
	// ----------------------------------------
	// The pin starts low so that releasing reset shows no edge.
	initial begin
		capture_pin = 1'b0;
	end

	// Whole pulses, entered just after a rising edge; rises are 2*half clocks apart, half being raised to at least 2.
	task automatic pulses(input int n, input int half);
		int h;
		h = (half < 2) ? 2 : half;
		for (int i = 0; i < n; i++) begin
			capture_pin <= 1'b1;
			repeat (h) @(posedge pclk);
			capture_pin <= 1'b0;
			repeat (h) @(posedge pclk);
		end
	endtask

	// ----------------------------------------
	// PWM output
	// ----------------------------------------
	// Counts the clocks at which the output is seen high.
	task automatic count_high(input int cycles, output int hi);
		hi = 0;
		repeat (cycles) begin
			@(posedge pclk);
			if (pwm_out === 1'b1) hi++;
		end
	endtask

endmodule

/* bench/timer_edge_capture_pwm_bench.sv */
// Self-checking bench for the timer half: registers, edge modes, PWM and wide timer.
`timescale 1ns/100ps
`include "timer_regs.svh"
module timer_edge_capture_pwm_bench;

	logic pclk;
	logic presetn;
	logic [11:0] paddr;
	logic psel;
	logic penable;
	logic pwrite;
	logic [31:0] pwdata;
	logic pready;
	logic [31:0] prdata;
	logic pslverr;
	logic capture_pin;
	logic pwm_out;
	int n_fail;
	int n_tests;

`define CHK(what, exp, got) begin n_tests++; if ((got) !== (exp)) begin n_fail++; \
	$display("MISMATCH %s expected %0h seen %0h", what, (exp), (got)); end end

	timer_edge_capture_pwm dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .capture_pin(capture_pin), .pwm_out(pwm_out));

	pin_partner partner_u (.pclk(pclk), .capture_pin(capture_pin), .pwm_out(pwm_out));

	// ----------------------------------------
	// Clock, verdict and watchdog
	// ----------------------------------------
	// The 4 ns clock runs from time zero, before any register access.
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	// Single place where the run ends.
	task automatic wrap_up();
		if (n_fail == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// The tests need well under 5000 clocks; a hang is cut off far beyond that.
	initial begin
		repeat (20000) @(posedge pclk);
		n_fail++;
		wrap_up();
	end

	// ----------------------------------------
	// APB master
	// ----------------------------------------
	// One transfer, entered just after a rising edge; only the watchdog ends a wait for pready.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask

	task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0, q, e);
		`CHK(what, exp, q)
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// Reset values, an unmapped address and a write to a read-only place.
	task automatic t_reset();
		logic [31:0] q;
		logic e;
		rd_chk("load", `OFF_LOAD, `LOAD_RESET);
		rd_chk("match", `OFF_MATCH, `MATCH_RESET);
		rd_chk("count", `OFF_CAPTURE, `COUNT_RESET);
		rd_chk("control", `OFF_CONTROL, 32'h0);
		apb(1'b0, 12'h008, 32'h0, q, e);
		`CHK("unmapped error", 1'b1, e)
		`CHK("unmapped data", 32'h0, q)
		wr(`OFF_RAW, 32'h7);
		rd_chk("raw ro", `OFF_RAW, 32'h0);
	endtask

	// Edge counting for each edge selection; edges past the match are ignored.
	task automatic t_edge_count();
		logic [1:0] evts [3];
		logic [31:0] ctl;
		int e;
		evts = '{`EVT_RISE, `EVT_FALL, `EVT_BOTH};
		foreach (evts[i]) begin
			ctl = 32'(evts[i]) << `CTL_EVT_LSB;
			e = (evts[i] == `EVT_BOTH) ? 2 : 1;
			wr(`OFF_CONTROL, 32'h0);
			wr(`OFF_CONFIG, 32'(`CFG_SPLIT));
			wr(`OFF_MODE, 32'(`TMODE_CAPTURE));
			wr(`OFF_LOAD, 32'hA);
			wr(`OFF_MATCH, 32'h6);
			wr(`OFF_CLEAR, 32'h7);
			wr(`OFF_CONTROL, ctl | 32'h1);
			partner_u.pulses(1, 3);
			repeat (6) @(posedge pclk);
			rd_chk("count step", `OFF_CAPTURE, 32'hA - 32'(e));
			rd_chk("no match yet", `OFF_RAW, 32'h0);
			partner_u.pulses(4 / e + 1, 2);
			repeat (6) @(posedge pclk);
			rd_chk("reloaded", `OFF_CAPTURE, 32'hA);
			rd_chk("enable off", `OFF_CONTROL, ctl);
			rd_chk("match raw", `OFF_RAW, 32'h2);
			rd_chk("match masked", `OFF_MASKED, 32'h2);
		end
	endtask

	// Two rising edges 200 clocks apart with a 101-state count; the second lands after two reloads.
	task automatic t_edge_time();
		logic [31:0] cap1;
		logic e;
		wr(`OFF_CONTROL, 32'h0);
		wr(`OFF_CONFIG, 32'(`CFG_SPLIT));
		wr(`OFF_MODE, (32'h1 << `MODE_CMR_BIT) | 32'(`TMODE_CAPTURE));
		wr(`OFF_LOAD, 32'h64);
		wr(`OFF_CLEAR, 32'h7);
		wr(`OFF_CONTROL, (32'(`EVT_RISE) << `CTL_EVT_LSB) | 32'h1);
		fork
			partner_u.pulses(2, 100);
			begin
				repeat (50) @(posedge pclk);
				apb(1'b0, `OFF_CAPTURE, 32'h0, cap1, e);
				`CHK("capture first", 32'h61, cap1)
				rd_chk("capture flags", `OFF_RAW, 32'h4);
				repeat (20) @(posedge pclk);
				rd_chk("capture held", `OFF_CAPTURE, cap1);
			end
		join
		rd_chk("capture wrap", `OFF_CAPTURE, (cap1 + 32'd2) % 32'd101);
		wr(`OFF_CONTROL, 32'h0);
	endtask

	// Period of ten clocks, active from count nine down to the match at three.
	task automatic t_pwm();
		int hi;
		wr(`OFF_CONTROL, 32'h0);
		wr(`OFF_CONFIG, 32'(`CFG_SPLIT));
		wr(`OFF_MODE, (32'h1 << `MODE_AMS_BIT) | 32'(`TMODE_PERIODIC));
		wr(`OFF_LOAD, 32'h9);
		wr(`OFF_MATCH, 32'h3);
		wr(`OFF_CLEAR, 32'h7);
		wr(`OFF_CONTROL, 32'h1);
		repeat (20) @(posedge pclk);
		partner_u.count_high(100, hi);
		`CHK("pwm high", 60, hi)
		rd_chk("pwm no flags", `OFF_RAW, 32'h0);
		wr(`OFF_CONTROL, 32'h1 | (32'h1 << `CTL_INV_BIT));
		rd_chk("invert bit", `OFF_CONTROL, 32'h41);
		repeat (10) @(posedge pclk);
		partner_u.count_high(100, hi);
		`CHK("pwm inverted", 40, hi)
		wr(`OFF_CONTROL, 32'h0);
	endtask

	// Wide timer: one-shot stops and its flags clear; periodic keeps timing out.
	task automatic t_timer();
		wr(`OFF_CONTROL, 32'h0);
		wr(`OFF_CONFIG, 32'(`CFG_WIDE));
		wr(`OFF_MODE, 32'(`TMODE_ONESHOT));
		wr(`OFF_LOAD, 32'd20);
		wr(`OFF_CLEAR, 32'h7);
		wr(`OFF_CONTROL, 32'h1);
		repeat (40) @(posedge pclk);
		rd_chk("oneshot stop", `OFF_CONTROL, 32'h0);
		rd_chk("timeout raw", `OFF_RAW, 32'h1);
		wr(`OFF_CLEAR, 32'h1);
		rd_chk("raw cleared", `OFF_RAW, 32'h0);
		rd_chk("masked cleared", `OFF_MASKED, 32'h0);
		wr(`OFF_MODE, 32'(`TMODE_PERIODIC));
		wr(`OFF_CONTROL, 32'h1);
		repeat (40) @(posedge pclk);
		wr(`OFF_CLEAR, 32'h1);
		repeat (30) @(posedge pclk);
		rd_chk("periodic runs", `OFF_CONTROL, 32'h1);
		rd_chk("periodic again", `OFF_MASKED, 32'h1);
		wr(`OFF_CONTROL, 32'h0);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	// Inputs get values at time zero; reset is held for twenty clocks.
	initial begin
		n_fail = 0;
		n_tests = 0;
		presetn = 1'b0;
		paddr = 12'h000;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		pwdata = 32'h0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		wr(`OFF_MASK, 32'h7);
		t_edge_count();
		t_edge_time();
		t_pwm();
		t_timer();
		wrap_up();
	end

endmodule
